// ---- hdl/ciee_entry.sv ----
// interrupt and exception entry sequencer: classify, push state, fetch vector
`timescale 1ns/1ns
`default_nettype none
module ciee_entry import ciee_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // instruction boundary from the core
  input wire logic instr_end,
  input wire logic [15:0] flags_in,
  input wire logic [15:0] cs_in,
  input wire logic [15:0] next_ip,
  input wire logic [15:0] instr_ip,
  input wire logic [15:0] prefix_ip,
  input wire logic seg_prefix,
  input wire logic [15:0] ss_in,
  input wire logic [15:0] sp_in,
  input wire logic step_suppress,
  input wire logic is_return,
  // conditions raised by the finishing instruction
  input wire logic div_overflow,
  input wire logic int_instr,
  input wire logic [7:0] int_type,
  input wire logic brk_instr,
  input wire logic into_instr,
  input wire logic bound_instr,
  input wire logic [15:0] bound_index,
  input wire logic [15:0] bound_lower,
  input wire logic [15:0] bound_upper,
  input wire logic undef_opcode,
  input wire logic [7:0] opcode,
  input wire logic coproc_trap_en,
  // hardware requests
  input wire logic nmi_pin,
  input wire logic [3:0] ext_request_lines,
  input wire logic ext_cascade,
  input wire logic [2:0] timer_req,
  input wire logic [1:0] dma_req,
  input wire logic [NSRC*LVL_W-1:0] prio_level,
  input wire logic prio_unique,
  output logic [NSRC-1:0] src_ack,
  // external acknowledge
  output logic inta_req,
  input wire logic inta_done,
  input wire logic [7:0] inta_vec,
  // memory port for stack and table
  output logic mem_req,
  output logic mem_we,
  output logic [19:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // results to the core
  output logic entry_busy,
  output logic entry_done,
  output logic [7:0] entry_type,
  output logic [15:0] new_cs,
  output logic [15:0] new_ip,
  output logic [15:0] new_sp,
  output logic [15:0] new_flags
);
  // physical address from segment and offset
  function automatic logic [19:0] phys(input logic [15:0] seg, input logic [15:0] ofs);
    return ({seg, 4'h0} + {4'h0, ofs});
  endfunction

  // table address of a vector type
  // RL2: 8-bit type spans all 256 entries
  function automatic logic [19:0] vec_addr(input logic [7:0] vt);
    return {10'h000, vt, 2'b00};
  endfunction

  ciee_state_t state_q, state_d;
  ciee_kind_t kind_q, kind_d;
  logic [4:0] pin_s1_q, pin_s2_q;
  logic nmi_old_q, nmi_pend_q, nmi_rise;
  logic [7:0] type_q, type_d, exc_type;
  logic [15:0] flags_q, cs_q, ret_ip_q, ss_q, sp_q, sp_d, ret_ip_d;
  logic [15:0] ofs_q;
  logic take, bnd, exc_hit, coproc_hit, bound_fail, mask_ok, step_hit, use_ack;
  logic [19:0] addr_d;
  logic [15:0] wdata_d;

  ciee_prio_if pif ();

  ciee_prio u_prio (
    .pif(pif.resolver)
  );

  // pins cross into the clock domain through two flops before any use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
    end else begin
      pin_s1_q <= {ext_request_lines, nmi_pin};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign pif.req = {pin_s2_q[4:1], dma_req, |timer_req};
  assign pif.timer_sub = timer_req;
  assign pif.level = prio_level;
  assign pif.unique_lvl = prio_unique;

  // non-maskable request is edge latched; a new edge beats the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nmi_old_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_old_q <= pin_s2_q[0];
      if (nmi_rise) begin
        nmi_pend_q <= 1'b1;
      end else if (take && kind_d == K_NMI) begin
        nmi_pend_q <= 1'b0;
      end
    end
  end
  assign nmi_rise = pin_s2_q[0] & ~nmi_old_q;

  // RL14: signed bounds check
  assign bound_fail = ($signed(bound_index) < $signed(bound_lower)) ||
                      ($signed(bound_index) > $signed(bound_upper));
  // RL16: trap only with enable bit
  assign coproc_hit = coproc_trap_en && opcode >= COPROC_LO && opcode <= COPROC_HI;
  // RL13: overflow trap gated by flag
  assign exc_hit = div_overflow | int_instr | brk_instr | (into_instr & flags_in[OF_BIT]) |
                   (bound_instr & bound_fail) | undef_opcode | coproc_hit;
  // RL22: restored flags gate pending requests
  // RL20: maskable gated by enable flag
  assign mask_ok = pif.grant_valid & flags_in[IF_BIT];
  // RL9: step after eligible instructions; RL23: restored flag arms the next one
  assign step_hit = flags_in[TF_BIT] & ~step_suppress & ~is_return;
  // RL5: sampling only at instruction end
  assign bnd = instr_end && state_q == S_IDLE;

  // instruction exception vector; only one can arise per instruction
  always_comb begin
    exc_type = VT_COPROC;
    // RL8: divide error
    if (div_overflow) begin
      exc_type = VT_DIV;
    end else if (int_instr) begin
      exc_type = int_type;
    end else if (brk_instr) begin
      // RL12: breakpoint type
      exc_type = VT_BRK;
    end else if (into_instr & flags_in[OF_BIT]) begin
      exc_type = VT_OVF;
    end else if (bound_instr & bound_fail) begin
      exc_type = VT_BOUND;
    end else if (undef_opcode) begin
      // RL15: undefined opcode
      exc_type = VT_UNDEF;
    end
  end

  // RL25: fixed order exception, non-maskable, maskable, step
  always_comb begin
    take = 1'b0;
    kind_d = kind_q;
    type_d = type_q;
    use_ack = 1'b0;
    // RL7: default return after the instruction
    ret_ip_d = next_ip;
    if (bnd) begin
      take = exc_hit | nmi_pend_q | mask_ok | step_hit;
      if (exc_hit) begin
        kind_d = K_EXC;
        type_d = exc_type;
        // RL6: coprocessor trap returns to opcode or prefix
        if (coproc_hit && !div_overflow && !int_instr && !brk_instr && !undef_opcode) begin
          ret_ip_d = seg_prefix ? prefix_ip : instr_ip;
        end
      end else if (nmi_pend_q) begin
        // RL10: internal type, no acknowledge
        kind_d = K_NMI;
        type_d = VT_NMI;
      end else if (mask_ok) begin
        kind_d = K_MASK;
        type_d = pif.grant_vec;
        // RL4: cascaded line supplies its type on acknowledge
        use_ack = ext_cascade && pif.grant_idx == SRC_EXT0[2:0];
      end else if (step_hit) begin
        kind_d = K_STEP;
        type_d = VT_STEP;
      end
    end
  end

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (take) begin
          state_d = use_ack ? S_ACK : S_PUSH_F;
        end
      end
      S_ACK: begin
        if (inta_done) begin
          state_d = S_PUSH_F;
        end
      end
      // RL1: status, segment, pointer in that order
      S_PUSH_F: begin
        if (mem_ack) begin
          state_d = S_PUSH_C;
        end
      end
      S_PUSH_C: begin
        if (mem_ack) begin
          state_d = S_PUSH_I;
        end
      end
      S_PUSH_I: begin
        if (mem_ack) begin
          state_d = S_RD_OFF;
        end
      end
      // RL24: offset word then segment word
      S_RD_OFF: begin
        if (mem_ack) begin
          state_d = S_RD_SEG;
        end
      end
      S_RD_SEG: begin
        if (mem_ack) begin
          state_d = S_DONE;
        end
      end
      S_DONE: begin
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // captured machine state of the interrupted program
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      kind_q <= K_EXC;
      type_q <= 8'h00;
      flags_q <= 16'h0000;
      cs_q <= 16'h0000;
      ret_ip_q <= 16'h0000;
      ss_q <= 16'h0000;
    end else if (take) begin
      kind_q <= kind_d;
      type_q <= type_d;
      flags_q <= flags_in;
      cs_q <= cs_in;
      ret_ip_q <= ret_ip_d;
      ss_q <= ss_in;
    end else if (state_q == S_ACK && inta_done) begin
      type_q <= inta_vec;
    end
  end

  // stack pointer moves down one word before each push
  always_comb begin
    sp_d = sp_q;
    if (take) begin
      sp_d = sp_in - STACK_STEP;
    end else if (mem_ack && (state_q == S_PUSH_F || state_q == S_PUSH_C)) begin
      sp_d = sp_q - STACK_STEP;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sp_q <= 16'h0000;
    end else begin
      sp_q <= sp_d;
    end
  end

  // RL3: table entry at type times four
  always_comb begin
    addr_d = 20'h00000;
    wdata_d = 16'h0000;
    case (state_d)
      S_PUSH_F: begin
        addr_d = phys(take ? ss_in : ss_q, sp_d);
        wdata_d = take ? flags_in : flags_q;
      end
      S_PUSH_C: begin
        addr_d = phys(ss_q, sp_d);
        wdata_d = cs_q;
      end
      S_PUSH_I: begin
        addr_d = phys(ss_q, sp_d);
        wdata_d = ret_ip_q;
      end
      S_RD_OFF: begin
        addr_d = vec_addr(type_q);
      end
      S_RD_SEG: begin
        addr_d = vec_addr(type_q) + VEC_SEG_OFS;
      end
      default: begin
        addr_d = 20'h00000;
      end
    endcase
  end

  // address and data held in flops so they are stable for the whole access
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_addr <= 20'h00000;
      mem_wdata <= 16'h0000;
    end else begin
      mem_addr <= addr_d;
      mem_wdata <= wdata_d;
    end
  end

  assign mem_req = state_q inside {S_PUSH_F, S_PUSH_C, S_PUSH_I, S_RD_OFF, S_RD_SEG};
  assign mem_we = state_q inside {S_PUSH_F, S_PUSH_C, S_PUSH_I};
  assign inta_req = (state_q == S_ACK);
  assign entry_busy = (state_q != S_IDLE);
  assign entry_done = (state_q == S_DONE);
  assign entry_type = type_q;
  assign new_sp = sp_q;

  // handler pointer loads from the table words
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ofs_q <= 16'h0000;
      new_ip <= 16'h0000;
      new_cs <= 16'h0000;
    end else if (mem_ack && state_q == S_RD_OFF) begin
      ofs_q <= mem_rdata;
    end else if (mem_ack && state_q == S_RD_SEG) begin
      new_ip <= ofs_q;
      new_cs <= mem_rdata;
    end
  end

  // RL11: enable flag off on every entry; RL21: pushed copy kept intact
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      new_flags <= 16'h0000;
    end else if (take) begin
      new_flags <= flags_in & ~(16'h0001 << IF_BIT) &
                   ((kind_d == K_STEP) ? ~(16'h0001 << TF_BIT) : 16'hFFFF);
    end
  end

  // acknowledge pulse to the granted maskable source
  always_comb begin
    src_ack = '0;
    if (take && kind_d == K_MASK) begin
      src_ack[pif.grant_idx] = 1'b1;
    end
  end

  // RL1: push sequence steps
  sequence push_f_s;
    state_q == S_PUSH_F && mem_ack;
  endsequence
  sequence push_c_s;
    state_q == S_PUSH_C && mem_we && mem_wdata == cs_q;
  endsequence

  push_order_a: assert property (@(posedge ref_clk) disable iff (rst) // RL1
    push_f_s |=> push_c_s) else $error("segment push does not follow status push");
  vec_addr_a: assert property (@(posedge ref_clk) disable iff (rst) // RL3
    state_q == S_RD_OFF |-> mem_addr == {10'h000, type_q, 2'b00})
    else $error("table read address wrong");
  hw_sample_a: assert property (@(posedge ref_clk) disable iff (rst) // RL5
    $rose(entry_busy) |-> $past(instr_end)) else $error("entry started off a boundary");
  div_type_a: assert property (@(posedge ref_clk) disable iff (rst) // RL8
    bnd && div_overflow |=> type_q == 8'h00 && entry_busy)
    else $error("divide error type wrong");
  nmi_type_a: assert property (@(posedge ref_clk) disable iff (rst) // RL10
    bnd && nmi_pend_q && !exc_hit |=> type_q == 8'h02 && !inta_req)
    else $error("non-maskable entry wrong");
  mask_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // RL20
    src_ack != '0 |-> flags_in[IF_BIT] && !exc_hit && !nmi_pend_q)
    else $error("maskable request taken while disabled");
  flags_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // RL21
    entry_done |-> !new_flags[IF_BIT]) else $error("enable flag left set");
  esc_ret_a: assert property (@(posedge ref_clk) disable iff (rst) // RL6
    bnd && coproc_hit && !div_overflow && !int_instr && !brk_instr && !undef_opcode
    |=> ret_ip_q == ($past(seg_prefix) ? $past(prefix_ip) : $past(instr_ip)))
    else $error("coprocessor trap return pointer wrong");
  seg_load_a: assert property (@(posedge ref_clk) disable iff (rst) // RL24
    state_q == S_RD_SEG && mem_ack |=> new_cs == $past(mem_rdata) && entry_done)
    else $error("handler segment load wrong");
endmodule
`default_nettype wire

// ---- common/ciee_pkg.sv ----
// constants and types of the interrupt and exception entry unit
// Function
// RL1: entry pushes status word, code segment and instruction pointer onto the stack
// RL2: vector table holds 256 routine pointers; types 0 to 31 are reserved
// RL3: every source calls indirectly through table entry at type times four
// RL4: 8-bit type; cascaded requester supplies it on acknowledge, others internal
// RL5: hardware requests sampled only at instruction end; software interrupts go first
// RL6: coprocessor trap returns to the opcode, or to its segment prefix
// RL7: other exceptions return to the instruction after the faulting one
// RL8: divide quotient overflow raises type 0
// RL9: set step flag raises type 1 except after prefix, segment load, wait
// RL10: non-maskable request ignores enable flag, type 2, no acknowledge cycle
// RL11: non-maskable service clears the enable flag at its start
// RL12: breakpoint instruction gives type 3, table index 12
// RL13: overflow trap instruction raises type 4 only with overflow flag set
// RL14: range check raises type 5 when index is outside the two bounds
// RL15: undefined opcode raises type 6
// RL16: coprocessor opcodes DB to DF raise type 7 only when trap enabled
// RL17: internal vectors: timers 8, 18, 19; channels 10, 11; lines 12 to 15
// RL18: timers share one level; timer zero over one over two
// RL19: default levels apply unless every source has a unique level
// RL20: maskable requests accepted only while the enable flag is set
// RL21: enable flag cleared after status word saved; saved copy unchanged
// RL22: return restores status; pending request served before main line resumes
// RL23: step entry clears step flag; restored status re-arms stepping
// RL24: table entry read as offset word then segment word, loaded to start
// RL25: fixed order: instruction exceptions, then non-maskable, maskable, step
package ciee_pkg;
  // vector types
  localparam logic [7:0] VT_DIV = 8'h00;
  localparam logic [7:0] VT_STEP = 8'h01;
  localparam logic [7:0] VT_NMI = 8'h02;
  localparam logic [7:0] VT_BRK = 8'h03;
  localparam logic [7:0] VT_OVF = 8'h04;
  localparam logic [7:0] VT_BOUND = 8'h05;
  localparam logic [7:0] VT_UNDEF = 8'h06;
  localparam logic [7:0] VT_COPROC = 8'h07;
  localparam logic [7:0] VT_TMR0 = 8'h08;
  localparam logic [7:0] VT_TMR1 = 8'h12;
  localparam logic [7:0] VT_TMR2 = 8'h13;
  localparam logic [7:0] VT_DMA0 = 8'h0A;
  localparam logic [7:0] VT_DMA1 = 8'h0B;
  localparam logic [7:0] VT_EXT0 = 8'h0C;
  localparam logic [7:0] VT_RSVD_TOP = 8'h1F;
  localparam int VT_COUNT = 256;
  // table entry spacing is one shift of two bits, i.e. times four
  localparam int VEC_SHIFT = 2;
  localparam logic [19:0] VEC_SEG_OFS = 20'h00002;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam int SEG_SHIFT = 4;
  // coprocessor opcode range
  localparam logic [7:0] COPROC_LO = 8'hDB;
  localparam logic [7:0] COPROC_HI = 8'hDF;
  // status word bit positions
  localparam int TF_BIT = 8;
  localparam int IF_BIT = 9;
  localparam int OF_BIT = 11;
  // maskable sources: 0 timers, 1 channel 0, 2 channel 1, 3..6 lines 0..3
  localparam int NSRC = 7;
  localparam int LVL_W = 3;
  localparam int SRC_EXT0 = 3;
  localparam logic [2:0] SRC_NONE = 3'h7;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ACK = 3'b001,
    S_PUSH_F = 3'b010,
    S_PUSH_C = 3'b011,
    S_PUSH_I = 3'b100,
    S_RD_OFF = 3'b101,
    S_RD_SEG = 3'b110,
    S_DONE = 3'b111
  } ciee_state_t;

  typedef enum logic [1:0] {
    K_EXC = 2'b00,
    K_NMI = 2'b01,
    K_MASK = 2'b10,
    K_STEP = 2'b11
  } ciee_kind_t;
endpackage

// ---- common/ciee_prio_if.sv ----
// request and grant signals between the entry unit and its priority resolver
`timescale 1ns/1ns
`default_nettype none
interface ciee_prio_if;
  import ciee_pkg::*;
  logic [NSRC-1:0] req;
  logic [2:0] timer_sub;
  logic [NSRC*LVL_W-1:0] level;
  logic unique_lvl;
  logic grant_valid;
  logic [2:0] grant_idx;
  logic [7:0] grant_vec;
  modport requester (output req, timer_sub, level, unique_lvl,
                     input grant_valid, grant_idx, grant_vec);
  modport resolver (input req, timer_sub, level, unique_lvl,
                    output grant_valid, grant_idx, grant_vec);
endinterface
`default_nettype wire

// ---- hdl/ciee_prio.sv ----
// maskable request priority resolver with internal vector generation
`timescale 1ns/1ns
`default_nettype none
module ciee_prio import ciee_pkg::*; (
  // request and grant
  ciee_prio_if.resolver pif
);
  // internal vector of a granted source
  function automatic logic [7:0] src_vec(input logic [2:0] idx, input logic [2:0] tsub);
    logic [7:0] v;
    v = VT_EXT0 + {5'h00, idx} - 8'h03;
    // RL18: timer zero over one over two
    if (idx == 3'h0) begin
      v = tsub[0] ? VT_TMR0 : (tsub[1] ? VT_TMR1 : VT_TMR2);
    end else if (idx == 3'h1) begin
      v = VT_DMA0;
    end else if (idx == 3'h2) begin
      v = VT_DMA1;
    end
    return v;
  endfunction

  logic [2:0] win;
  logic [LVL_W-1:0] best;

  // lowest level wins; ties and default mode fall to the lower index
  always_comb begin
    win = SRC_NONE;
    best = '1;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pif.req[i]) begin
        // RL19: default order unless levels unique
        if (!pif.unique_lvl || win == SRC_NONE ||
            pif.level[i*LVL_W +: LVL_W] <= best) begin
          win = i[2:0];
          best = pif.level[i*LVL_W +: LVL_W];
        end
      end
    end
  end

  assign pif.grant_valid = (win != SRC_NONE);
  assign pif.grant_idx = win;
  // RL17: internal vectors per source
  assign pif.grant_vec = src_vec(win, pif.timer_sub);
endmodule
`default_nettype wire

// ---- testbench/ciee_far_model.sv ----
// far side model: stack and vector memory plus cascaded acknowledge responder
`timescale 1ns/1ns
`default_nettype none
module ciee_far_model (
  // clock and bench controls
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic [7:0] casc_vec,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [19:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  // acknowledge cycle
  input wire logic inta_req,
  output logic inta_done,
  output logic [7:0] inta_vec
);
  logic [15:0] wr [logic [19:0]];
  logic [1:0] mwait_q = 2'h0;
  logic [1:0] iwait_q = 2'h0;
  logic [15:0] rd_last_q = 16'h0000;
  // table words encode their own address so handler pointers are predictable
  assign mem_ack = mem_req && (mwait_q == (slow ? 2'h3 : 2'h0));
  // released data lines show the inverse so a stale sample cannot pass
  assign mem_rdata = mem_ack ? {4'hC, mem_addr[11:0]} : ~rd_last_q;
  assign inta_done = inta_req && (iwait_q == 2'h2);
  assign inta_vec = inta_done ? casc_vec : ~casc_vec;
  // wait counters and write capture
  always @(posedge ref_clk) begin
    mwait_q <= (mem_req && !mem_ack) ? mwait_q + 2'h1 : 2'h0;
    iwait_q <= (inta_req && !inta_done) ? iwait_q + 2'h1 : 2'h0;
    if (mem_ack && !mem_we) rd_last_q <= mem_rdata;
    if (mem_ack && mem_we) wr[mem_addr] = mem_wdata;
  end
endmodule
`default_nettype wire

// ---- testbench/test_cpu_interrupt_exception_entry.sv ----
// self-checking bench for the interrupt and exception entry sequencer
`timescale 1ns/1ns
`default_nettype none
module test_cpu_interrupt_exception_entry;
  import ciee_pkg::*;
  logic ref_clk, rst, instr_end, seg_prefix, step_suppress, is_return, div_overflow;
  logic int_instr, brk_instr, into_instr, bound_instr, undef_opcode, coproc_trap_en;
  logic nmi_pin, ext_cascade, prio_unique, inta_req, inta_done, mem_req, mem_we, mem_ack;
  logic entry_busy, entry_done, slow;
  logic [15:0] flags_in, cs_in, next_ip, instr_ip, prefix_ip, ss_in, sp_in;
  logic [15:0] bound_index, bound_lower, bound_upper, mem_wdata, mem_rdata;
  logic [15:0] new_cs, new_ip, new_sp, new_flags;
  logic [7:0] int_type, opcode, inta_vec, entry_type, casc_vec;
  logic [3:0] ext_request_lines;
  logic [2:0] timer_req;
  logic [1:0] dma_req;
  logic [NSRC*LVL_W-1:0] prio_level;
  logic [NSRC-1:0] src_ack;
  logic [19:0] mem_addr;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  ciee_entry uut (.*);
  ciee_far_model far (.ref_clk(ref_clk), .slow(slow), .casc_vec(casc_vec),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .inta_req(inta_req),
    .inta_done(inta_done), .inta_vec(inta_vec));

  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      summarize();
    end
  end

  task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-shot instruction conditions drop after the boundary
  task automatic clear();
    div_overflow = 1'b0;
    int_instr = 1'b0;
    brk_instr = 1'b0;
    into_instr = 1'b0;
    bound_instr = 1'b0;
    undef_opcode = 1'b0;
    opcode = 8'h90;
    seg_prefix = 1'b0;
    step_suppress = 1'b0;
    is_return = 1'b0;
    timer_req = 3'h0;
    dma_req = 2'h0;
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // one instruction boundary; entered and left one step after a rising edge
  task automatic boundary(input logic take, input logic [7:0] typ, input logic [15:0] ret,
                          input logic [6:0] ack);
    logic got;
    logic [6:0] ack_seen;
    logic [19:0] sa;
    logic [15:0] fl;
    got = 1'b0;
    sa = {ss_in, 4'h0} + {4'h0, sp_in};
    fl = flags_in & 16'hFDFF;
    if (typ === VT_STEP) fl[TF_BIT] = 1'b0;
    far.wr.delete();
    instr_end = 1'b1;
    @(negedge ref_clk);
    ack_seen = src_ack;
    pause(1);
    instr_end = 1'b0;
    clear();
    for (int i = 0; i < 40 && !got; i++) begin
      @(negedge ref_clk);
      got = (entry_done === 1'b1);
    end
    chk("entry", {19'h0, got}, {19'h0, take});
    chk("src_ack", {13'h0, ack_seen}, {13'h0, ack});
    if (take) begin
      chk("type", {12'h0, entry_type}, {12'h0, typ});
      chk("new_ip", {4'h0, new_ip}, {8'h0C, 2'b00, typ, 2'b00});
      chk("new_cs", {4'h0, new_cs}, {8'h0C, 2'b00, typ, 2'b10});
      chk("push_flags", {4'h0, far.wr[sa - 20'h2]}, {4'h0, flags_in});
      chk("push_cs", {4'h0, far.wr[sa - 20'h4]}, {4'h0, cs_in});
      chk("push_ip", {4'h0, far.wr[sa - 20'h6]}, {4'h0, ret});
      chk("new_sp", {4'h0, new_sp}, {4'h0, sp_in - 16'h0006});
      chk("new_flags", {4'h0, new_flags}, {4'h0, fl});
    end
    pause(2);
  endtask

  initial begin
    clear();
    rst = 1'b1;
    instr_end = 1'b0;
    slow = 1'b0;
    casc_vec = 8'h40;
    flags_in = 16'h0200;
    cs_in = 16'h2000;
    next_ip = 16'h0105;
    instr_ip = 16'h0100;
    prefix_ip = 16'h00FF;
    ss_in = 16'h1000;
    sp_in = 16'h0100;
    int_type = 8'h00;
    bound_index = 16'h0000;
    bound_lower = 16'h0000;
    bound_upper = 16'h000A;
    coproc_trap_en = 1'b0;
    nmi_pin = 1'b0;
    ext_request_lines = 4'h0;
    ext_cascade = 1'b0;
    prio_level = '0;
    prio_unique = 1'b0;
    pause(8);
    rst = 1'b0;
    pause(3);
    // instruction exceptions
    div_overflow = 1'b1;
    boundary(1'b1, VT_DIV, next_ip, 7'h00);
    int_instr = 1'b1;
    int_type = 8'hFF;
    boundary(1'b1, 8'hFF, next_ip, 7'h00);
    brk_instr = 1'b1;
    boundary(1'b1, VT_BRK, next_ip, 7'h00);
    into_instr = 1'b1;
    boundary(1'b0, VT_OVF, next_ip, 7'h00);
    flags_in = 16'h0A00;
    into_instr = 1'b1;
    boundary(1'b1, VT_OVF, next_ip, 7'h00);
    flags_in = 16'h0200;
    bound_instr = 1'b1;
    bound_index = 16'h0005;
    boundary(1'b0, VT_BOUND, next_ip, 7'h00);
    bound_instr = 1'b1;
    bound_index = 16'hFFFF;
    boundary(1'b1, VT_BOUND, next_ip, 7'h00);
    undef_opcode = 1'b1;
    boundary(1'b1, VT_UNDEF, next_ip, 7'h00);
    // coprocessor trap, disabled then each opcode, with prefix on the odd opcodes only
    opcode = COPROC_LO;
    boundary(1'b0, VT_COPROC, instr_ip, 7'h00);
    coproc_trap_en = 1'b1;
    for (int op = 8'hDB; op <= 8'hDF; op++) begin
      opcode = op[7:0];
      seg_prefix = op[0];
      boundary(1'b1, VT_COPROC, op[0] ? prefix_ip : instr_ip, 7'h00);
    end
    coproc_trap_en = 1'b0;
    // maskable sources, refused while the enable flag is clear
    flags_in = 16'h0000;
    timer_req = 3'h1;
    boundary(1'b0, VT_TMR0, next_ip, 7'h00);
    flags_in = 16'h0200;
    timer_req = 3'h7;
    boundary(1'b1, VT_TMR0, next_ip, 7'h01);
    timer_req = 3'h6;
    boundary(1'b1, VT_TMR1, next_ip, 7'h01);
    timer_req = 3'h4;
    dma_req = 2'h1;
    boundary(1'b1, VT_TMR2, next_ip, 7'h01);
    prio_unique = 1'b1;
    prio_level = {3'h7, 3'h7, 3'h7, 3'h7, 3'h6, 3'h0, 3'h5};
    timer_req = 3'h4;
    dma_req = 2'h1;
    boundary(1'b1, VT_DMA0, next_ip, 7'h02);
    prio_unique = 1'b0;
    dma_req = 2'h2;
    boundary(1'b1, VT_DMA1, next_ip, 7'h04);
    // external line three, through the pin synchroniser
    ext_request_lines = 4'h8;
    pause(4);
    boundary(1'b1, VT_EXT0 + 8'h03, next_ip, 7'h40);
    ext_request_lines = 4'h0;
    pause(4);
    // cascaded line zero with a slow memory
    ext_cascade = 1'b1;
    slow = 1'b1;
    ext_request_lines = 4'h1;
    pause(4);
    boundary(1'b1, casc_vec, next_ip, 7'h08);
    ext_request_lines = 4'h0;
    ext_cascade = 1'b0;
    slow = 1'b0;
    pause(4);
    // non-maskable with enable clear, losing to a coinciding exception
    flags_in = 16'h0000;
    nmi_pin = 1'b1;
    pause(5);
    div_overflow = 1'b1;
    boundary(1'b1, VT_DIV, next_ip, 7'h00);
    boundary(1'b1, VT_NMI, next_ip, 7'h00);
    nmi_pin = 1'b0;
    flags_in = 16'h0200;
    // software interrupt goes ahead of a sampled timer request
    int_instr = 1'b1;
    int_type = 8'h21;
    timer_req = 3'h1;
    boundary(1'b1, 8'h21, next_ip, 7'h00);
    // single step, suppressed step, and return with a pending request
    flags_in = 16'h0100;
    boundary(1'b1, VT_STEP, next_ip, 7'h00);
    step_suppress = 1'b1;
    boundary(1'b0, VT_STEP, next_ip, 7'h00);
    flags_in = 16'h0300;
    is_return = 1'b1;
    timer_req = 3'h1;
    boundary(1'b1, VT_TMR0, next_ip, 7'h01);
    summarize();
  end
endmodule
`default_nettype wire
